// file: btr_consts.svh
// constants for the basic timer reload and control block
// assumes a single 25 MHz clock and a plain register port
// What this block does
// - on automatic restart the counter loads the reload value
// - 16-bit variant: reload upper bits read zero and ignore writes
// - 32-bit variant: all reload bits read/write, reload width equals counter width
// - status bit 0 is set when the counter reaches its limit
// - with auto restart the flag is a one-cycle pulse, otherwise a held level
// - enable bit 0 gates the status flag onto the interrupt output
// - prescaler bits 31:16 give one enable pulse every setting plus one clocks
// - start bit 5 runs counter to its limit, then clears itself
// - in auto restart mode start stays set until software clears it
// - setting start resets divider, begins counting, clears pending status
// - clearing start disables divider and halts the counter
// - soft reset bit 4 is write-only, self-clears, resets the block
// - auto restart bit 3 reloads count on completion, edge interrupt
// - auto restart zero enters done state, waits, level interrupt
// - direction bit counts up saturating at all ones, or down to zero
// - internal reset is system reset or soft reset, all registers default
`ifndef BTR_CONSTS_SVH
`define BTR_CONSTS_SVH
`define BTR_OFS_COUNT    8'h00
`define BTR_OFS_RELOAD   8'h04
`define BTR_OFS_STATUS   8'h08
`define BTR_OFS_IRQ_EN   8'h0C
`define BTR_OFS_CONTROL  8'h10
`define BTR_BIT_LIMIT    0
`define BTR_BIT_DIR      0
`define BTR_BIT_RESTART  3
`define BTR_BIT_SOFTRST  4
`define BTR_BIT_START    5
`define BTR_PS_HI        31
`define BTR_PS_LO        16
`define BTR_CTRL_MASK    32'hFFFF_00E9
`define BTR_ZERO32       32'h0000_0000
`define BTR_ZERO16       16'h0000
`define BTR_ONE16        16'h0001
`endif

// file: btr_irq_gate.sv
// interrupt output flop gated by the enable bit
// assumes status and enable come from registers in the top
`timescale 1ns/1ns
module btr_irq_gate (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // inputs
  input  wire logic status,
  input  wire logic enable,
  // output
  output logic      irq
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= status & enable;
  end

  a_irq_gating: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == $past(status & enable)) else $error("interrupt not gated by enable");
endmodule : btr_irq_gate

// file: btr_pkg.sv
// types for the basic timer block
// assumes btr_consts.svh is included by users of the offsets
package btr_pkg;
  typedef enum logic [1:0] {btr_idle, btr_run, btr_done} btr_state_e;
  typedef logic [31:0] btr_word_t;
endpackage : btr_pkg

// file: btr_prescaler.sv
// clock-enable divider for the timer
// assumes the caller holds reset for soft reset as well
`timescale 1ns/1ns
`include "btr_consts.svh"
module btr_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  btr_tick_if.div  tk
);
  logic [15:0] div_count;

  // a changed divisor mid-run takes effect at once; one at or below the current count ticks on the next clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= `BTR_ZERO16;
      tk.tick   <= 1'b0;
    end else if (tk.restart || !tk.run) begin
      div_count <= `BTR_ZERO16;
      tk.tick   <= 1'b0;
    end else if (div_count >= tk.divisor) begin
      div_count <= `BTR_ZERO16;
      tk.tick   <= 1'b1;
    end else begin
      div_count <= div_count + `BTR_ONE16;
      tk.tick   <= 1'b0;
    end
  end

  a_tick_cleared_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tk.run |=> !tk.tick) else $error("tick while stopped");
  a_tick_full_speed: assert property (@(posedge core_clk) disable iff (!rst_n)
    tk.run && !tk.restart && tk.divisor == `BTR_ZERO16 && $past(tk.run) && !$past(tk.restart)
    |=> tk.tick) else $error("divisor zero must tick every clock");
endmodule : btr_prescaler

// file: btr_tick_if.sv
// divider enable signals between the top and the prescaler
// assumes one clock domain
`timescale 1ns/1ns
interface btr_tick_if;
  logic        run;
  logic        restart;
  logic [15:0] divisor;
  logic        tick;
  modport ctl (output run, output restart, output divisor, input tick);
  modport div (input run, input restart, input divisor, output tick);
endinterface : btr_tick_if

// file: btr_timer.sv
// basic timer top: registers, counter, status and interrupt
// assumes synchronous bus strobes, read data one cycle after the read strobe
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "btr_consts.svh"
module btr_timer import btr_pkg::*; #(
  parameter int WIDE = 1
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  btr_word_t  count;
  btr_word_t  reload_value;
  logic       limit_status;
  logic       limit_irq_enable;
  btr_word_t  timer_control;
  logic       soft_reset;
  logic       rst_n;
  btr_state_e state;
  logic       start_rise;
  btr_word_t  top_value;
  btr_tick_if tk ();

  function automatic btr_word_t fit(input btr_word_t v);
    fit = (WIDE != 0) ? v : {`BTR_ZERO16, v[15:0]};
  endfunction : fit

  assign top_value = fit(32'hFFFF_FFFF);
  // soft reset is a registered pulse, so the or never glitches from logic
  assign rst_n = nrst & ~soft_reset;

  logic wr_ctrl;
  logic start_bit;
  logic restart_bit;
  logic count_up;
  logic at_limit;
  logic step;
  assign wr_ctrl     = wr_stb && addr == `BTR_OFS_CONTROL;
  assign start_bit   = timer_control[`BTR_BIT_START];
  assign restart_bit = timer_control[`BTR_BIT_RESTART];
  assign count_up    = timer_control[`BTR_BIT_DIR];
  assign at_limit    = count_up ? (count == top_value) : (count == `BTR_ZERO32);
  assign step        = tk.tick && start_bit && state == btr_run;
  assign start_rise  = wr_ctrl && wdata[`BTR_BIT_START] && !start_bit;

  assign tk.run     = start_bit;
  assign tk.restart = start_rise;
  assign tk.divisor = timer_control[`BTR_PS_HI:`BTR_PS_LO];

  ////////////////////////////////////////////////////////////////////////////
  // soft reset runs on the system reset only, so it can release itself
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) soft_reset <= 1'b0;
    else       soft_reset <= wr_ctrl && wdata[`BTR_BIT_SOFTRST];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reload_value <= `BTR_ZERO32;
    else if (wr_stb && addr == `BTR_OFS_RELOAD) reload_value <= fit(wdata);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) limit_irq_enable <= 1'b0;
    else if (wr_stb && addr == `BTR_OFS_IRQ_EN) limit_irq_enable <= wdata[`BTR_BIT_LIMIT];
  end

  // control register; start clears itself on a one-shot limit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) timer_control <= `BTR_ZERO32;
    else if (wr_ctrl) timer_control <= wdata & `BTR_CTRL_MASK;
    else if (step && at_limit && !restart_bit) timer_control[`BTR_BIT_START] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) count <= `BTR_ZERO32;
    else if (wr_stb && addr == `BTR_OFS_COUNT) count <= fit(wdata);
    else if (step && at_limit && restart_bit) count <= reload_value;
    else if (step && !at_limit) count <= fit(count_up ? count + 32'h1 : count - 32'h1);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) state <= btr_idle;
    else begin
      case (state)
        btr_idle: if (start_rise) state <= btr_run;
        btr_run: begin
          if (wr_ctrl && !wdata[`BTR_BIT_START]) state <= btr_idle;
          else if (step && at_limit && !restart_bit) state <= btr_done;
        end
        btr_done: if (start_rise) state <= btr_run;
        default: state <= btr_idle;
      endcase
    end
  end

  // limit flag: pulse in restart mode, level otherwise; a new hit beats a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) limit_status <= 1'b0;
    else if (step && at_limit) limit_status <= 1'b1;
    else if (restart_bit && limit_status) limit_status <= 1'b0;
    else if (start_rise) limit_status <= 1'b0;
    else if (rd_stb && addr == `BTR_OFS_STATUS) limit_status <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata <= `BTR_ZERO32;
    else if (rd_stb) begin
      case (addr)
        `BTR_OFS_COUNT:   rdata <= count;
        `BTR_OFS_RELOAD:  rdata <= reload_value;
        `BTR_OFS_STATUS:  rdata <= {31'h0, limit_status};
        `BTR_OFS_IRQ_EN:  rdata <= {31'h0, limit_irq_enable};
        `BTR_OFS_CONTROL: rdata <= timer_control;
        default:          rdata <= `BTR_ZERO32;
      endcase
    end else rdata <= `BTR_ZERO32;
  end

  btr_prescaler btr_prescaler_inst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tk       (tk)
  );

  btr_irq_gate btr_irq_gate_inst (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .status   (limit_status),
    .enable   (limit_irq_enable),
    .irq      (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_reload_on_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    step && at_limit && restart_bit && !wr_stb |=> count == $past(reload_value)) else $error("no reload");
  a_reload_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    WIDE == 0 |-> reload_value[31:16] == `BTR_ZERO16) else $error("reload upper bits set");
  a_limit_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    step && at_limit |=> limit_status) else $error("limit flag missing");
  a_pulse_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    limit_status && restart_bit && !(step && at_limit) |=> !limit_status) else $error("pulse too long");
  a_start_self_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    step && at_limit && !restart_bit && !wr_ctrl |=> !start_bit ##0 state == btr_done) else $error("start held");
  a_start_clears_stat: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_rise && !(step && at_limit) |=> !limit_status) else $error("status kept on start");
  a_stop_halts_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    !start_bit && !wr_stb |=> count == $past(count)) else $error("count moved while stopped");
  a_soft_reset_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
    soft_reset |=> !soft_reset) else $error("soft reset stuck");
  a_up_saturates: assert property (@(posedge core_clk) disable iff (!rst_n)
    count_up && at_limit && !restart_bit && !wr_stb |=> count == $past(count)) else $error("no saturation");
  c_oneshot_done: cover property (@(posedge core_clk) disable iff (!rst_n) state == btr_done);
  c_restart_reload: cover property (@(posedge core_clk) disable iff (!rst_n) step && at_limit && restart_bit);
  c_irq_raised: cover property (@(posedge core_clk) disable iff (!rst_n) irq);
  c_soft_reset: cover property (@(posedge core_clk) soft_reset);
endmodule : btr_timer

// file: test_btr_timer.sv
// self-checking bench for the basic timer, both widths side by side
// assumes the design files are compiled first; drives the register port directly
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_btr_timer import btr_pkg::*;;
  logic       core_clk = 1'b0;
  logic       nrst     = 1'b0;
  logic [7:0] addr     = 8'h00;
  btr_word_t  wdata    = 32'h0;
  logic       wr_stb   = 1'b0;
  logic       rd_stb   = 1'b0;
  btr_word_t  rdata, rdata16, d, d16, a;
  logic       irq, irq16;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         c0, c1;
  btr_word_t  w;
  //////////////////////////////////////////////////////////////////////
  btr_timer #(.WIDE(1)) btr_timer_inst (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
  // narrow variant shares the bus so every reload and count write also exercises its masking
  btr_timer #(.WIDE(0)) btr_timer16_inst (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata16), .irq(irq16));
  always #20 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////
  function automatic btr_word_t f_ctrl(input btr_word_t v);
    return v & 32'hFFFF_00C9;
  endfunction : f_ctrl
  // cycles from a start write to a visible interrupt: divider start, n steps, limit step, flag, flop
  function automatic int f_wait(input int n, input int p);
    return 4 + p + n * (p + 1);
  endfunction : f_wait
  task automatic wr(input logic [7:0] ad, input btr_word_t v);
    @(posedge core_clk);
    addr <= ad; wdata <= v; wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge core_clk);
    addr <= ad; rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    d = rdata; d16 = rdata16;
  endtask : rd
  // bounded wait so a dead timer cannot hang the run
  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 200) begin
      @(negedge core_clk);
      c++;
    end
  endtask : wait_irq
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(63));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h04); `CHK("reload", 32'h0, d)
    rd(8'h08); `CHK("status", 32'h0, d)
    rd(8'h0C); `CHK("irq_en", 32'h0, d)
    rd(8'h10); `CHK("control", 32'h0, d)
    rd(8'h14); `CHK("unmapped", 32'h0, d)
    for (int i = 0; i < 6; i++) begin
      w = $urandom();
      wr(8'h04, w);
      rd(8'h04); `CHK("reload32", w, d)
      `CHK("reload16", {16'h0, w[15:0]}, d16)
      w = $urandom() & 32'hFFFF_FFCF;
      wr(8'h10, w);
      rd(8'h10); `CHK("control", f_ctrl(w), d)
    end
    wr(8'h10, 32'h0);
    wr(8'h0C, 32'h1);
    rd(8'h0C); `CHK("irq_en", 32'h1, d)
    // one-shot up to saturation
    wr(8'h00, 32'hFFFF_FFFD);
    wr(8'h10, 32'h0000_0021);
    wait_irq(c0); `CHK("irq up", 1'b1, irq)
    `CHK("irq16 up", 1'b1, irq16)
    rd(8'h10); `CHK("start cleared", 32'h1, d)
    rd(8'h08); `CHK("status level", 32'h1, d)
    rd(8'h08); `CHK("status read clear", 32'h0, d)
    repeat (2) @(negedge core_clk);
    `CHK("irq low", 1'b0, irq)
    // down count from three, prescale 0 then 2
    wr(8'h00, 32'h3); wr(8'h10, 32'h0000_0020);
    wait_irq(c0); `CHK("wait p0", f_wait(3, 0), c0)
    rd(8'h00); `CHK("down zero", 32'h0, d)
    rd(8'h08);
    // prescaler only changed while stopped
    wr(8'h00, 32'h3); wr(8'h10, 32'h0002_0020);
    wait_irq(c1); rd(8'h08);
    `CHK("prescale", f_wait(3, 2) - f_wait(3, 0), c1 - c0)
    // auto restart: pulse, start kept, reload used
    wr(8'h04, 32'hFFFF_FFF0); wr(8'h00, 32'hFFFF_FFFE);
    wr(8'h10, 32'h0000_0029);
    wait_irq(c0); `CHK("pulse hi", 1'b1, irq)
    @(negedge core_clk); `CHK("pulse lo", 1'b0, irq)
    rd(8'h10); `CHK("start kept", 32'h29, d)
    rd(8'h00); `CHK("reloaded", 1'b1, d inside {[32'hFFFF_FFF0:32'hFFFF_FFFE]})
    `CHK("reloaded16", 1'b1, d16 inside {[32'h0000_FFF0:32'h0000_FFFE]})
    wr(8'h10, 32'h0);
    rd(8'h00); a = d;
    repeat (5) @(negedge core_clk);
    rd(8'h00); `CHK("halted", a, d)
    // masked limit, then restart clears status
    wr(8'h0C, 32'h0); rd(8'h08);
    wr(8'h00, 32'h2); wr(8'h10, 32'h0000_0020);
    repeat (20) @(negedge core_clk);
    `CHK("masked irq", 1'b0, irq)
    // unmask without reading, so the held level shows and start must clear it
    wr(8'h0C, 32'h1);
    repeat (2) @(negedge core_clk);
    `CHK("masked status", 1'b1, irq)
    wr(8'h00, 32'h0000_0064); wr(8'h10, 32'h0000_0020);
    rd(8'h08); `CHK("start clears", 32'h0, d)
    // soft reset returns everything to defaults
    wr(8'h04, 32'h1234_5678); wr(8'h0C, 32'h1);
    wr(8'h10, 32'h0000_0010);
    repeat (2) @(posedge core_clk);
    rd(8'h04); `CHK("sr reload", 32'h0, d)
    rd(8'h0C); `CHK("sr irq_en", 32'h0, d)
    rd(8'h10); `CHK("sr control", 32'h0, d)
    final_report();
  end
endmodule : test_btr_timer
